// [secu_pkg.sv]
package secu_pkg;
  // gpib error codes
  localparam logic [4:0] SECU_NO_GPIB_ERR = 5'h00;
  localparam logic [4:0] SECU_IO_ABORTED_ERR = 5'h06;
  localparam logic [4:0] SECU_CAPABILITY_DISABLED_ERR = 5'h0B;
  localparam logic [4:0] SECU_COMMAND_SEND_ERR = 5'h0E;
  localparam logic [4:0] SECU_UNKNOWN_FUNCTION_ERR = 5'h11;
  // serial error codes
  localparam logic [2:0] SECU_NO_SERIAL_ERR = 3'h0;
  localparam logic [2:0] SECU_PARITY_ERR = 3'h1;
  localparam logic [2:0] SECU_OVERRUN_ERR = 3'h2;
  localparam logic [2:0] SECU_BUFFER_OVERFLOW_ERR = 3'h3;
  localparam logic [2:0] SECU_FRAMING_ERR = 3'h4;
  // character frame: start + data + parity + stop
  localparam int SECU_START_BITS = 1;
  localparam int SECU_DEFAULT_DATA_BITS = 8;
  localparam int SECU_DEFAULT_BIT_CYCLES = 1042;
  // receive line space level (break = line held low)
  localparam logic SECU_SPACE = 1'b0;

  typedef enum logic [1:0] {
    SECU_IDLE = 2'b00,
    SECU_MSG = 2'b01,
    SECU_XFER = 2'b10
  } secu_state_t;
endpackage

// [secu_error_unit.sv]
module secu_error_unit
  import secu_pkg::*;
#(
  parameter int DATA_BITS = SECU_DEFAULT_DATA_BITS,
  parameter int BIT_CYCLES = SECU_DEFAULT_BIT_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,

  // configuration
  input wire logic ignore_serial_errs,
  input wire logic parity_en,
  input wire logic parity_odd,
  input wire logic g_mode,

  // receive line and receiver events
  input wire logic rx_line,
  input wire logic rx_char_valid,
  input wire logic [DATA_BITS-1:0] rx_char,
  input wire logic rx_parity_bit,
  input wire logic rx_stop_bit,
  input wire logic rx_char_pending,
  input wire logic rx_buf_full,

  // receive data passed on
  output logic rx_out_valid,
  output logic [DATA_BITS-1:0] rx_out_data,

  // operation control from command logic
  input wire logic op_start,
  input wire logic msg_start,
  input wire logic msg_end,
  input wire logic xfer_start,
  input wire logic xfer_end,

  // gpib-side error events
  input wire logic io_cancelled,
  input wire logic cap_disabled,
  input wire logic func_is_g_mode,
  input wire logic func_valid,
  input wire logic func_unknown,
  input wire logic cmd_send_fail,

  // results
  output logic msg_discard,
  output logic xfer_abort,
  output logic [4:0] gpib_error,
  output logic [2:0] serial_error,
  output logic err_flag
);
  import secu_pkg::*;

  // frame is start, data, one parity slot and one stop, whether or not parity is on
  localparam int FRAME_BITS = SECU_START_BITS + DATA_BITS + 2;
  localparam int BREAK_CYCLES = FRAME_BITS * BIT_CYCLES;
  // one spare count so a saturated counter is told apart from the limit itself
  localparam int CW = $clog2(BREAK_CYCLES + 2);
  localparam logic [CW-1:0] BREAK_LIMIT = CW'(BREAK_CYCLES);
  localparam logic [CW-1:0] CNT_STEP = CW'(1);

  // character widths outside 5..8 have no framing in the receiver
  initial begin
    if (DATA_BITS < 5) begin
      $error("secu_error_unit: DATA_BITS below 5 not supported");
    end
    if (DATA_BITS > 8) begin
      $error("secu_error_unit: DATA_BITS above 8 not supported");
    end
    if (BIT_CYCLES < 1) begin
      $error("secu_error_unit: BIT_CYCLES must be at least 1");
    end
  end

  secu_state_t state;
  secu_state_t next_state;

  // break detection
  logic [CW-1:0] space_cnt;
  logic break_seen;
  logic break_evt;

  // serial and gpib code selection
  logic parity_bad;
  logic [2:0] next_serial;
  logic ser_evt;
  logic [4:0] next_gpib;
  logic gpib_evt;

  // per-character conditions, judged only in the cycle a character is presented; gpib terms and recording also follow func_valid and break events
  logic stop_missing;
  logic buf_overflow;
  logic char_overrun;
  logic char_parity;
  logic mode_mismatch;
  logic gpib_any;
  logic ser_record;
  logic char_keep;

  assign stop_missing = rx_char_valid && (rx_stop_bit == SECU_SPACE);

  // only expected when both flow-control schemes are off
  assign buf_overflow = rx_char_valid && rx_buf_full;

  // pending means the previous character was never taken, so it is lost
  assign char_overrun = rx_char_valid && rx_char_pending;

  assign char_parity = rx_char_valid && parity_bad;

  // a function of the other command set counts as a disabled capability
  assign mode_mismatch = func_valid && (func_is_g_mode != g_mode);

  assign gpib_any = io_cancelled || cmd_send_fail || func_unknown || cap_disabled || mode_mismatch;

  // ignoring masks recording, discard and abort alike
  assign ser_record = ser_evt && !ignore_serial_errs;

  // bad bytes still pass when ignoring, so the host sees what arrived
  assign char_keep = rx_char_valid && (!ser_evt || ignore_serial_errs);

  // break counter; saturates one past the frame time so a long break cannot wrap
  // and raise a second event within the same low period
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      space_cnt <= '0;
    end else if (rx_line != SECU_SPACE) begin
      space_cnt <= '0;
    end else if (space_cnt <= BREAK_LIMIT) begin
      space_cnt <= space_cnt + CNT_STEP;
    end
  end

  // one event per break, rearmed only when the line returns to mark
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      break_seen <= 1'b0;
    end else if (rx_line != SECU_SPACE) begin
      break_seen <= 1'b0;
    end else if (space_cnt > BREAK_LIMIT) begin
      break_seen <= 1'b1;
    end
  end

  // strictly longer than a whole frame, so a long run of zero data is not a break
  assign break_evt = (space_cnt > BREAK_LIMIT) && !break_seen;

  // even parity: data xor parity bit is 0; odd: 1
  logic [DATA_BITS:0] par_chain;
  assign par_chain[0] = rx_parity_bit;
  for (genvar i = 0; i < DATA_BITS; i++) begin : g_par
    assign par_chain[i+1] = par_chain[i] ^ rx_char[i];
  end
  assign parity_bad = parity_en && (par_chain[DATA_BITS] != parity_odd);

  // priority: break/framing, overflow, overrun, parity
  always_comb begin
    next_serial = SECU_NO_SERIAL_ERR;
    ser_evt = 1'b1;
    if (break_evt) begin
      next_serial = SECU_FRAMING_ERR;
    end else if (stop_missing) begin
      next_serial = SECU_FRAMING_ERR;
    end else if (buf_overflow) begin
      next_serial = SECU_BUFFER_OVERFLOW_ERR;
    end else if (char_overrun) begin
      next_serial = SECU_OVERRUN_ERR;
    end else if (char_parity) begin
      next_serial = SECU_PARITY_ERR;
    end else begin
      ser_evt = 1'b0;
    end
  end

  // ranking: cancel, send failure, unknown name, capability
  always_comb begin
    next_gpib = SECU_NO_GPIB_ERR;
    gpib_evt = 1'b1;
    if (io_cancelled) begin
      next_gpib = SECU_IO_ABORTED_ERR;
    end else if (cmd_send_fail) begin
      next_gpib = SECU_COMMAND_SEND_ERR;
    end else if (func_unknown) begin
      next_gpib = SECU_UNKNOWN_FUNCTION_ERR;
    end else if (cap_disabled || mode_mismatch) begin
      next_gpib = SECU_CAPABILITY_DISABLED_ERR;
    end else begin
      gpib_evt = 1'b0;
    end
  end

  // what the command logic is currently receiving or moving
  always_comb begin
    next_state = state;
    case (state)
      SECU_IDLE: begin
        if (xfer_start) begin
          next_state = SECU_XFER;
        end else if (msg_start) begin
          next_state = SECU_MSG;
        end
      end
      SECU_MSG: begin
        if (msg_end || msg_discard) begin
          next_state = SECU_IDLE;
        end
      end
      SECU_XFER: begin
        if (xfer_end || xfer_abort) begin
          next_state = SECU_IDLE;
        end
      end
      default: begin
        next_state = SECU_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= SECU_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // one-cycle pulses; errors ignored when requested
  assign msg_discard = (state == SECU_MSG) && !g_mode && ser_record;
  // transfers abort in either command-set mode
  assign xfer_abort = (state == SECU_XFER) && ser_record;

  // erroneous bytes dropped unless ignoring
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_out_valid <= 1'b0;
    end else begin
      rx_out_valid <= char_keep;
    end
  end

  // data follows every presented character; only the valid pulse qualifies it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_out_data <= '0;
    end else if (rx_char_valid) begin
      rx_out_data <= rx_char;
    end
  end

  // codes cleared at the start of each operation; an error in that cycle still wins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      serial_error <= SECU_NO_SERIAL_ERR;
    end else if (ser_record) begin
      serial_error <= next_serial;
    end else if (op_start) begin
      serial_error <= SECU_NO_SERIAL_ERR;
    end
  end

  // kept apart from the serial code so both can be read after one operation
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gpib_error <= SECU_NO_GPIB_ERR;
    end else if (gpib_evt) begin
      gpib_error <= next_gpib;
    end else if (op_start) begin
      gpib_error <= SECU_NO_GPIB_ERR;
    end
  end

  // flag follows either code; an error in the clearing cycle keeps it set
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      err_flag <= 1'b0;
    end else if (gpib_any || ser_record) begin
      err_flag <= 1'b1;
    end else if (op_start) begin
      err_flag <= 1'b0;
    end
  end
endmodule

// [secu_error_unit_props.sv]
module secu_error_unit_props
  import secu_pkg::*;
(
  // watched ports
  input wire logic clk, rst_n, ignore_serial_errs, g_mode, rx_char_valid, rx_stop_bit,
  input wire logic io_cancelled, cap_disabled, func_is_g_mode, func_valid, func_unknown,
  input wire logic cmd_send_fail, op_start, msg_discard, xfer_abort, err_flag,
  input wire logic [4:0] gpib_error,
  input wire logic [2:0] serial_error
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire logic bad = rx_char_valid && !ignore_serial_errs;
  wire logic hi = io_cancelled || cmd_send_fail || func_unknown;
  property p_io; io_cancelled |=> gpib_error == SECU_IO_ABORTED_ERR; endproperty
  a_io: assert property (p_io) else $error("io code");
  property p_bus; cmd_send_fail && !io_cancelled |=> gpib_error == SECU_COMMAND_SEND_ERR; endproperty
  a_bus: assert property (p_bus) else $error("send code");
  property p_unk; func_unknown && !io_cancelled && !cmd_send_fail |=> gpib_error == 5'h11; endproperty
  a_unk: assert property (p_unk) else $error("unknown code");
  property p_cap; (cap_disabled || func_valid && func_is_g_mode != g_mode) && !hi |=> gpib_error == 5'h0B; endproperty
  a_cap: assert property (p_cap) else $error("cap code");
  property p_frm; bad && !rx_stop_bit |=> serial_error == SECU_FRAMING_ERR; endproperty
  a_frm: assert property (p_frm) else $error("frame code");
  property p_ign; ignore_serial_errs && !op_start |=> $stable(serial_error); endproperty
  a_ign: assert property (p_ign) else $error("ignored code");
  property p_flag; gpib_error != 5'h00 || serial_error != 3'h0 |-> err_flag; endproperty
  a_flag: assert property (p_flag) else $error("flag");
  property p_dsc; msg_discard |-> !g_mode && !ignore_serial_errs ##1 serial_error != 3'h0; endproperty
  a_dsc: assert property (p_dsc) else $error("discard");
  property p_abt; xfer_abort |-> !ignore_serial_errs ##1 serial_error != 3'h0; endproperty
  a_abt: assert property (p_abt) else $error("abort");
endmodule

// [secu_serial_peer.sv]
module secu_serial_peer (
  // clock
  input wire logic clk,
  // receiver side
  output logic rx_line,
  output logic rx_char_valid,
  output logic [7:0] rx_char,
  output logic rx_parity_bit,
  output logic rx_stop_bit
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {rx_line, rx_char_valid, rx_char, rx_parity_bit, rx_stop_bit} = 12'h800;
  // fields inverted outside the valid cycle so stale values never look right
  task automatic send(input logic [7:0] d, input logic p, input logic s);
    {rx_char, rx_parity_bit, rx_stop_bit, rx_char_valid} = {d, p, s, 1'h1};
    @(negedge clk);
    {rx_char, rx_parity_bit, rx_stop_bit, rx_char_valid} = {~d, ~p, ~s, 1'h0};
  endtask
  task automatic brk(input int n);
    rx_line = 1'h0;
    repeat (n) @(negedge clk);
    rx_line = 1'h1;
  endtask
endmodule

// [secu_error_unit_tb.sv]
module secu_error_unit_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'h0, rst_n = 1'h0, ignore_serial_errs, parity_en, parity_odd, g_mode, rx_char_pending;
  logic rx_buf_full, op_start, msg_start, msg_end, xfer_start, xfer_end, io_cancelled, cap_disabled;
  logic func_is_g_mode, func_valid, func_unknown, cmd_send_fail, rx_line, rx_char_valid, rx_parity_bit;
  logic rx_stop_bit, rx_out_valid, msg_discard, xfer_abort, err_flag;
  logic [7:0] rx_char, rx_out_data;
  logic [4:0] gpib_error;
  logic [2:0] serial_error;
  logic [1:0] hits;
  logic [8:0] q[$];
  int bad_count = 0, tests_run = 0;
  secu_error_unit #(.DATA_BITS(8), .BIT_CYCLES(4)) dut_u (.*);
  secu_serial_peer peer_u (.*);
  always #50 clk = ~clk;
  always @(posedge clk) hits <= hits | {msg_discard, xfer_abort};
  task automatic cmp(input logic [8:0] got, input logic [8:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  always @(negedge clk) while (q.size() > 0) cmp({err_flag, gpib_error, serial_error}, q.pop_front());
  task automatic note(input logic [4:0] g, input logic [2:0] s);
    q.push_back({g != 5'h00 || s != 3'h0, g, s});
    @(negedge clk);
  endtask
  task automatic pulse(ref logic s);
    s = 1'h1;
    @(negedge clk);
    s = 1'h0;
  endtask
  // mask: io, send, unknown, cap, func valid, op start
  task automatic ev(input logic [5:0] m, input logic [4:0] e);
    {io_cancelled, cmd_send_fail, func_unknown, cap_disabled, func_valid, op_start} = m;
    @(negedge clk);
    {io_cancelled, cmd_send_fail, func_unknown, cap_disabled, func_valid, op_start} = 6'h00;
    note(e, 3'h0);
  endtask
  // mask: stop ok, bad parity, buffer full, pending
  task automatic chr(input logic [3:0] m, input logic [2:0] e);
    logic [7:0] d;
    d = $urandom;
    {op_start, rx_buf_full, rx_char_pending} = {1'h1, m[1:0]};
    peer_u.send(d, ^d ^ parity_odd ^ m[2], m[3]);
    {op_start, rx_buf_full, rx_char_pending} = 3'h0;
    if (e == 3'h0) cmp({rx_out_valid, rx_out_data}, {1'h1, d});
    note(5'h00, ignore_serial_errs ? 3'h0 : e);
  endtask
  task automatic report_and_stop;
    if (bad_count == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (3000) @(negedge clk);
    bad_count++;
    report_and_stop();
  end
  initial begin
    {ignore_serial_errs, parity_odd, g_mode, rx_char_pending, rx_buf_full, msg_start, msg_end} = 7'h00;
    {xfer_start, xfer_end, op_start, io_cancelled, cap_disabled, func_valid, func_unknown, cmd_send_fail} = 8'h00;
    {parity_en, func_is_g_mode, hits} = 4'hC;
    void'($urandom(47));
    repeat (6) @(negedge clk);
    rst_n = 1'h1;
    ev(6'h21, 5'h06);
    ev(6'h11, 5'h0E);
    ev(6'h09, 5'h11);
    ev(6'h05, 5'h0B);
    ev(6'h03, 5'h0B);
    ev(6'h3B, 5'h06);
    ev(6'h01, 5'h00);
    g_mode = 1'h1;
    ev(6'h03, 5'h00);
    g_mode = 1'h0;
    repeat (2) begin
      parity_odd = $urandom;
      chr(4'h8, 3'h0);
      chr(4'h0, 3'h4);
      chr(4'hA, 3'h3);
      chr(4'h9, 3'h2);
      chr(4'hC, 3'h1);
    end
    hits = 2'h0;
    pulse(msg_start);
    chr(4'h0, 3'h4);
    pulse(msg_end);
    cmp(hits, 2'h2);
    {hits, g_mode} = 3'h1;
    pulse(xfer_start);
    chr(4'hC, 3'h1);
    pulse(xfer_end);
    cmp(hits, 2'h1);
    {hits, g_mode, ignore_serial_errs} = 4'h1;
    pulse(msg_start);
    chr(4'h0, 3'h0);
    cmp(hits, 2'h0);
    pulse(msg_end);
    ignore_serial_errs = 1'h0;
    ev(6'h01, 5'h00);
    peer_u.brk(40);
    note(5'h00, 3'h0);
    peer_u.brk(50);
    note(5'h00, 3'h4);
    report_and_stop();
  end
endmodule
bind secu_error_unit secu_error_unit_props props_u (.*);
